// file: hdl/cache_line_maintenance.sv
/*
 cache_line_maintenance: executes data-cache flush/invalidate by index or
 on hit, instruction-cache line invalidate and pipeline flush.
 Assumes the pipeline issues one op as a one-cycle opValid and waits for
 opDone; memory takes write-back beats with wbReady.
*/
// Added by the designer: the register offsets and strobed register access.
// How it works
// - address is base plus sign-extended immediate
// - flush by index picks line, no tag
// - flush by index writes dirty, then invalidates
// - processor stores mark line dirty
// - flush on hit compares stored tag
// - tag miss on hit ops does nothing
// - hit and dirty writes back, then invalidates
// - hit ops raise four exceptions: supervisor address and three translation faults
// - no data cache leaves the lines untouched, but hit ops still raise exceptions
// - icache line from base, unconditional invalidate
// - no icache makes icache invalidate nop
// - pipeline flush discards prefetched instructions
// - init by index picks line, no tag
// - init by index drops dirty data
`timescale 1ns/100ps
`default_nettype none
module cache_line_maintenance #(
   parameter bit DCACHE_PRESENT = 1'b1,
   parameter bit ICACHE_PRESENT = 1'b1,
   parameter int IC_LINE_W      = 4,
   parameter int IC_LINE_LSB    = 5
) (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  opValid,
   input  wire cache_maint_pkg::opReq_t               opReq,
   input  wire logic                                  userMode,
   input  wire cache_maint_pkg::xlateFault_t          xlateFault,
   output logic                                       stall,
   output logic                                       opDone,
   output logic                                       excValid,
   output cache_maint_pkg::excCause_t                 excCause,
   output logic                                       pipeFlush,
   output logic                                       icInvValid,
   output logic      [IC_LINE_W-1:0]                  icInvLine,
   input  wire logic                                  fillValid,
   input  wire logic                                  fillLast,
   input  wire cache_maint_pkg::memBeat_t             fillBeat,
   input  wire logic                                  storeValid,
   input  wire cache_maint_pkg::memBeat_t             storeBeat,
   output logic                                       wbValid,
   output cache_maint_pkg::memBeat_t                  wbBeat,
   input  wire logic                                  wbReady,
   input  wire logic [4:0]                            regAddr,
   input  wire logic [31:0]                           regWdata,
   input  wire logic                                  regWr,
   input  wire logic                                  regRd,
   output logic      [31:0]                           regRdata,
   output logic                                       irq
);
   import cache_maint_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WB} state_t;

   state_t            state_r;
   opKind_t           op_r;
   logic [ADDR_W-1:0] ea_r;
   logic [31:0]       base_r;
   logic              user_r;
   xlateFault_t       fault_r;
   logic [EV_W-1:0]   status_r;
   logic [EV_W-1:0]   enable_r;
   logic              supChk_r;
   logic [31:0]       wbCount_r;
   logic              accept;
   logic              isData;
   logic              isHit;
   logic              isFlush;
   logic              tagHit;
   logic              selLine;
   logic              needWb;
   logic              wbStart;
   logic              wbDone;
   logic              invValid;
   logic              finish;
   excCause_t         cause;
   logic [EV_W-1:0]   events;
   logic [TAG_W-1:0]  rdTag;
   logic              rdValid;
   logic              rdDirty;
   logic [31:0]       rdData;
   logic [WSEL_W-1:0] wordSel;

   assign accept = opValid && state_r == ST_IDLE;

   // op decode
   assign isData  = op_r inside {OP_FLUSH_IDX, OP_FLUSH_HIT, OP_INIT_IDX, OP_INIT_HIT};
   assign isHit   = op_r inside {OP_FLUSH_HIT, OP_INIT_HIT};
   assign isFlush = op_r inside {OP_FLUSH_IDX, OP_FLUSH_HIT};
   assign tagHit  = rdValid && rdTag == tagOf(ea_r);

   // exceptions only for the on-hit ops, in fixed priority
   always_comb begin
      cause = EXC_NONE;
      if (isHit) begin
         if (supChk_r && user_r && ea_r[SUPER_BIT]) cause = EXC_SUPER_ADDR;
         else if (fault_r.fastMiss)                  cause = EXC_FAST_MISS;
         else if (fault_r.doubleMiss)                cause = EXC_DOUBLE_MISS;
         else if (fault_r.mpuRegion)                 cause = EXC_MPU_REGION;
      end
   end

   // index ops take the line blindly, hit ops need a tag match
   assign selLine  = DCACHE_PRESENT && isData && cause == EXC_NONE
                     && (!isHit || tagHit);
   assign needWb   = selLine && isFlush && rdDirty;
   assign wbStart  = state_r == ST_EXEC && needWb;
   // invalidate in the execute cycle when no write-back is needed, else only after the last beat is taken
   assign invValid = (state_r == ST_EXEC && selLine && !needWb)
                     || (state_r == ST_WB && wbDone);
   assign finish   = (state_r == ST_EXEC && !needWb) || (state_r == ST_WB && wbDone);

   // latch the op and form its effective address
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_r    <= OP_PIPE_FLUSH;
         ea_r    <= '0;
         base_r  <= '0;
         user_r  <= 1'b0;
         fault_r <= '0;
      end else if (accept) begin
         op_r    <= opReq.op;
         ea_r    <= effAddr(opReq.baseRegisterOperand, opReq.signedOffsetImmediate);
         base_r  <= opReq.baseRegisterOperand;
         user_r  <= userMode;
         fault_r <= xlateFault;
      end
   end

   // sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: if (accept) state_r <= ST_EXEC;
            ST_EXEC: state_r <= needWb ? ST_WB : ST_IDLE;
            ST_WB:   if (wbDone) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // pipeline handshake: stall from acceptance to completion
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stall    <= 1'b0;
         opDone   <= 1'b0;
         excValid <= 1'b0;
         excCause <= EXC_NONE;
      end else begin
         opDone   <= finish;
         excValid <= state_r == ST_EXEC && cause != EXC_NONE;
         excCause <= state_r == ST_EXEC ? cause : EXC_NONE;
         if (accept) stall <= 1'b1;
         else if (finish) stall <= 1'b0;
      end
   end

   // instruction-side side effects
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pipeFlush  <= 1'b0;
         icInvValid <= 1'b0;
         icInvLine  <= '0;
      end else begin
         pipeFlush  <= state_r == ST_EXEC && op_r == OP_PIPE_FLUSH;
         icInvValid <= ICACHE_PRESENT && state_r == ST_EXEC
                       && op_r == OP_ICACHE_INV;
         if (state_r == ST_EXEC) icInvLine <= base_r[IC_LINE_LSB +: IC_LINE_W];
      end
   end

   line_tag_store uStore (
      .clk        (clk),
      .rstn       (rstn),
      .rdLine     (lineOf(ea_r)),
      .rdWord     (wordSel),
      .rdTag      (rdTag),
      .rdValid    (rdValid),
      .rdDirty    (rdDirty),
      .rdData     (rdData),
      .fillValid  (fillValid),
      .fillLast   (fillLast),
      .fillBeat   (fillBeat),
      .storeValid (storeValid),
      .storeBeat  (storeBeat),
      .invValid   (invValid),
      .invLine    (lineOf(ea_r))
   );

   // write-back goes to the address the stored tag names
   writeback_engine uWb (
      .clk       (clk),
      .rstn      (rstn),
      .start     (wbStart),
      .lineBase  ({rdTag, lineOf(ea_r), {LINE_LSB{1'b0}}}),
      .wordSel   (wordSel),
      .wordData  (rdData),
      .beatValid (wbValid),
      .beat      (wbBeat),
      .beatReady (wbReady),
      .done      (wbDone)
   );

   // sticky events; a new event beats a clear in the same cycle
   assign events = {wbDone, state_r == ST_EXEC && cause != EXC_NONE, finish};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~((regWr && regAddr == OFS_CLEAR) ? regWdata[EV_W-1:0] : '0))
                     | events;
      end
   end

   // software-written control
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enable_r <= ENABLE_RST;
         supChk_r <= SUPCHK_RST;
      end else if (regWr) begin
         if (regAddr == OFS_ENABLE) enable_r <= regWdata[EV_W-1:0];
         if (regAddr == OFS_CTRL)   supChk_r <= regWdata[CTRL_SUPCHK];
      end
   end

   // write-back counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) wbCount_r <= '0;
      else if (wbDone) wbCount_r <= wbCount_r + 32'h1;
   end

   // read data for one cycle only, zero elsewhere and for unmapped offsets
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= '0;
      end else if (regRd) begin
         case (regAddr)
            OFS_STATUS:  regRdata <= {{(32-EV_W){1'b0}}, status_r};
            OFS_ENABLE:  regRdata <= {{(32-EV_W){1'b0}}, enable_r};
            OFS_CTRL:    regRdata <= {31'h0, supChk_r};
            OFS_WBCOUNT: regRdata <= wbCount_r;
            default:     regRdata <= '0;
         endcase
      end else begin
         regRdata <= '0;
      end
   end

   // interrupt level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) irq <= 1'b0;
      else       irq <= |(status_r & enable_r);
   end

   a_ea_form: assert property (@(posedge clk) disable iff (!rstn)
      accept |=> ea_r == $past(opReq.baseRegisterOperand)
         + {{16{$past(opReq.signedOffsetImmediate[15])}}, $past(opReq.signedOffsetImmediate)})
      else $error("effective address wrong");
   a_idx_flush_wb: assert property (@(posedge clk) disable iff (!rstn)
      state_r == ST_EXEC && op_r == OP_FLUSH_IDX && DCACHE_PRESENT && rdDirty
      |=> wbValid && wbBeat.addr == {$past(rdTag), $past(lineOf(ea_r)), 4'h0})
      else $error("dirty line not written back by index flush");
   a_miss_idle: assert property (@(posedge clk) disable iff (!rstn)
      state_r == ST_EXEC && isHit && !tagHit |-> !invValid && !wbStart ##1 !wbValid)
      else $error("tag miss acted on line");
   a_idx_no_exc: assert property (@(posedge clk) disable iff (!rstn)
      state_r == ST_EXEC && !isHit |=> !excValid)
      else $error("exception from non-hit op");
   a_no_dcache: assert property (@(posedge clk) disable iff (!rstn)
      !DCACHE_PRESENT |-> !wbValid && !invValid)
      else $error("data op acted without data cache");
   a_icache_inv: assert property (@(posedge clk) disable iff (!rstn)
      accept && opReq.op == OP_ICACHE_INV && ICACHE_PRESENT |-> ##2 icInvValid
         && icInvLine == $past(opReq.baseRegisterOperand[IC_LINE_LSB +: IC_LINE_W], 2)
         && !excValid)
      else $error("icache line not invalidated");
   a_no_icache: assert property (@(posedge clk) disable iff (!rstn)
      !ICACHE_PRESENT |-> !icInvValid)
      else $error("icache invalidate without icache");
   a_pipe_flush: assert property (@(posedge clk) disable iff (!rstn)
      accept && opReq.op == OP_PIPE_FLUSH |-> ##2 pipeFlush && opDone && !excValid)
      else $error("pipeline flush missing");
   a_init_no_wb: assert property (@(posedge clk) disable iff (!rstn)
      state_r == ST_EXEC && !isFlush |-> !wbStart)
      else $error("init op wrote back");
   a_wb_stalls: assert property (@(posedge clk) disable iff (!rstn)
      wbValid |-> stall && !opDone && state_r == ST_WB)
      else $error("write-back not under stall");
endmodule : cache_line_maintenance
`default_nettype wire

// file: hdl/cache_maint_pkg.sv
/*
 cache_maint_pkg: geometry, register map, op codes and carriers for the
 cache line maintenance block.
 Assumes a 32-bit byte-addressed processor with a direct-mapped data cache.
*/
package cache_maint_pkg;
   localparam int ADDR_W    = 32;
   localparam int IMM_W     = 16;
   localparam int WORD_BITS = 2;                     // byte-offset bits, four bytes in a word
   localparam int WSEL_W    = 2;                     // four words per line
   localparam int LINE_W    = 3;                     // eight data lines
   localparam int LINE_LSB  = WORD_BITS + WSEL_W;
   localparam int TAG_LSB   = LINE_LSB + LINE_W;
   localparam int TAG_W     = ADDR_W - TAG_LSB;
   localparam int SUPER_BIT = 31;                    // top half is supervisor-only
   // register offsets
   localparam logic [4:0] OFS_STATUS  = 5'h00;
   localparam logic [4:0] OFS_CLEAR   = 5'h04;
   localparam logic [4:0] OFS_ENABLE  = 5'h08;
   localparam logic [4:0] OFS_CTRL    = 5'h0c;
   localparam logic [4:0] OFS_WBCOUNT = 5'h10;
   // event bit positions in status, clear and enable
   localparam int EV_DONE = 0;
   localparam int EV_EXC  = 1;
   localparam int EV_WB   = 2;
   localparam int EV_W    = 3;
   localparam int CTRL_SUPCHK = 0;
   // reset values
   localparam logic [EV_W-1:0] ENABLE_RST = 3'h0;
   localparam logic            SUPCHK_RST = 1'b1;

   typedef enum logic [2:0] {
      OP_FLUSH_IDX, OP_FLUSH_HIT, OP_INIT_IDX, OP_INIT_HIT, OP_ICACHE_INV, OP_PIPE_FLUSH
   } opKind_t;
   typedef enum logic [2:0] {
      EXC_NONE, EXC_SUPER_ADDR, EXC_FAST_MISS, EXC_DOUBLE_MISS, EXC_MPU_REGION
   } excCause_t;
   typedef struct packed {
      opKind_t           op;
      logic [31:0]       baseRegisterOperand;
      logic [IMM_W-1:0]  signedOffsetImmediate;
   } opReq_t;
   typedef struct packed {
      logic fastMiss;
      logic doubleMiss;
      logic mpuRegion;
   } xlateFault_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       data;
   } memBeat_t;

   // base plus sign-extended immediate
   function automatic logic [ADDR_W-1:0] effAddr(input logic [31:0] b,
                                                 input logic [IMM_W-1:0] i);
      return b + {{(ADDR_W-IMM_W){i[IMM_W-1]}}, i};
   endfunction : effAddr
   function automatic logic [LINE_W-1:0] lineOf(input logic [ADDR_W-1:0] a);
      return a[LINE_LSB +: LINE_W];
   endfunction : lineOf
   function automatic logic [TAG_W-1:0] tagOf(input logic [ADDR_W-1:0] a);
      return a[TAG_LSB +: TAG_W];
   endfunction : tagOf
   function automatic logic [WSEL_W-1:0] wordOf(input logic [ADDR_W-1:0] a);
      return a[WORD_BITS +: WSEL_W];
   endfunction : wordOf
endpackage : cache_maint_pkg

// file: hdl/line_tag_store.sv
/*
 line_tag_store: tag, valid, dirty and data flip-flops of the data cache.
 Assumes fills and stores come from the pipeline, which is stalled while a
 maintenance op runs, so invalidation never meets a store on the same line.
*/
`timescale 1ns/100ps
`default_nettype none
module line_tag_store (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic [cache_maint_pkg::LINE_W-1:0]    rdLine,
   input  wire logic [cache_maint_pkg::WSEL_W-1:0]    rdWord,
   output logic      [cache_maint_pkg::TAG_W-1:0]     rdTag,
   output logic                                       rdValid,
   output logic                                       rdDirty,
   output logic      [31:0]                           rdData,
   input  wire logic                                  fillValid,
   input  wire logic                                  fillLast,
   input  wire cache_maint_pkg::memBeat_t             fillBeat,
   input  wire logic                                  storeValid,
   input  wire cache_maint_pkg::memBeat_t             storeBeat,
   input  wire logic                                  invValid,
   input  wire logic [cache_maint_pkg::LINE_W-1:0]    invLine
);
   import cache_maint_pkg::*;
   localparam int LINES = 1 << LINE_W;
   localparam int WORDS = 1 << WSEL_W;

   logic [TAG_W-1:0] tag_r   [LINES];
   logic [31:0]      data_r  [LINES][WORDS];
   logic [LINES-1:0] valid_r;
   logic [LINES-1:0] dirty_r;
   logic             storeHit;

   // a store only lands in a resident line
   assign storeHit = storeValid && valid_r[lineOf(storeBeat.addr)]
                     && tag_r[lineOf(storeBeat.addr)] == tagOf(storeBeat.addr);

   assign rdTag   = tag_r[rdLine];
   assign rdValid = valid_r[rdLine];
   assign rdDirty = dirty_r[rdLine];
   assign rdData  = data_r[rdLine][rdWord];

   // tag and data words, no reset needed
   always_ff @(posedge clk) begin
      if (fillValid) begin
         data_r[lineOf(fillBeat.addr)][wordOf(fillBeat.addr)] <= fillBeat.data;
         if (fillLast) tag_r[lineOf(fillBeat.addr)] <= tagOf(fillBeat.addr);
      end
      if (storeHit) data_r[lineOf(storeBeat.addr)][wordOf(storeBeat.addr)] <= storeBeat.data;
   end

   // per-line valid and dirty state
   for (genvar g = 0; g < LINES; g++) begin : gLine
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            valid_r[g] <= 1'b0;
            dirty_r[g] <= 1'b0;
         end else if (invValid && invLine == g) begin
            valid_r[g] <= 1'b0;
            dirty_r[g] <= 1'b0;
         end else if (fillValid && fillLast && lineOf(fillBeat.addr) == g) begin
            valid_r[g] <= 1'b1;
            dirty_r[g] <= 1'b0;
         end else if (storeHit && lineOf(storeBeat.addr) == g) begin
            dirty_r[g] <= 1'b1;
         end
      end
   end

   a_store_dirty: assert property (@(posedge clk) disable iff (!rstn)
      storeHit && !invValid |=> dirty_r[$past(lineOf(storeBeat.addr))])
      else $error("store hit did not mark line dirty");
   a_inv_clean: assert property (@(posedge clk) disable iff (!rstn)
      invValid |=> !valid_r[$past(invLine)] && !dirty_r[$past(invLine)])
      else $error("invalidated line kept valid or dirty");
endmodule : line_tag_store
`default_nettype wire

// file: hdl/writeback_engine.sv
/*
 writeback_engine: sends one dirty line to memory, word by word, with a
 valid/ready handshake; pulses done after the last word is taken.
 Assumes the line stays put in the store until done.
*/
`timescale 1ns/100ps
`default_nettype none
module writeback_engine (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  start,
   input  wire logic [cache_maint_pkg::ADDR_W-1:0]    lineBase,
   output logic      [cache_maint_pkg::WSEL_W-1:0]    wordSel,
   input  wire logic [31:0]                           wordData,
   output logic                                       beatValid,
   output cache_maint_pkg::memBeat_t                  beat,
   input  wire logic                                  beatReady,
   output logic                                       done
);
   import cache_maint_pkg::*;
   localparam logic [WSEL_W-1:0] LAST = '1;

   logic [WSEL_W-1:0] idx_r;
   logic [ADDR_W-1:0] base_r;

   // word to fetch for the next beat
   assign wordSel = start ? '0 : WSEL_W'(idx_r + 1'b1);

   // beat sequencing
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idx_r     <= '0;
         base_r    <= '0;
         beatValid <= 1'b0;
         beat      <= '0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            idx_r     <= '0;
            base_r    <= lineBase;
            beatValid <= 1'b1;
            beat      <= '{addr: lineBase, data: wordData};
         end else if (beatValid && beatReady) begin
            if (idx_r == LAST) begin
               beatValid <= 1'b0;
               done      <= 1'b1;
            end else begin
               idx_r <= wordSel;
               beat  <= '{addr: base_r + {{(ADDR_W-WSEL_W-WORD_BITS){1'b0}}, wordSel,
                                          {WORD_BITS{1'b0}}}, data: wordData};
            end
         end
      end
   end
endmodule : writeback_engine
`default_nettype wire

// file: tb/mem_model.sv
/*
 mem_model: memory side that takes write-back beats.
 Assumes beats come on clk with a valid/ready handshake.
*/
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      slow,
   input  wire logic                      wbValid,
   input  wire cache_maint_pkg::memBeat_t wbBeat,
   output logic                           wbReady,
   output int                             cnt,
   output cache_maint_pkg::memBeat_t      log [4]
);
   import cache_maint_pkg::*;
   // ready every cycle, or every other one when slow
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) wbReady <= 1'b0;
      else wbReady <= slow ? ~wbReady : 1'b1;
   end
   // log each beat taken
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cnt <= 0;
      else if (wbValid && wbReady) begin
         log[cnt[1:0]] <= wbBeat;
         cnt <= cnt + 1;
      end
   end
endmodule : mem_model
`default_nettype wire

// file: tb/tb_cache_line_maintenance.sv
/*
 tb_cache_line_maintenance: directed scenarios for the maintenance block.
 Assumes mem_model answers write-backs; fills and stores come from here.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_cache_line_maintenance;
   import cache_maint_pkg::*;
   localparam logic [31:0] A = 32'h0000_0a30;
   logic clk = 0, rstn = 0, opValid = 0, userMode = 0, slow = 0, regWr = 0, regRd = 0;
   logic fillValid = 0, fillLast = 0, storeValid = 0, exv, pf, ic;
   logic stall, opDone, excValid, pipeFlush, icInvValid, wbValid, wbReady, irq;
   logic [3:0] icInvLine, icl;
   logic [4:0] regAddr = '0;
   logic [31:0] regWdata = '0, regRdata, d;
   opReq_t opReq = '0;
   xlateFault_t xlateFault = '0;
   memBeat_t fillBeat = '0, storeBeat = '0, wbBeat;
   memBeat_t log [4];
   excCause_t excCause, exc;
   int cnt, num_errors = 0, total_checks = 0, b0;
   cache_line_maintenance uut (.*);
   mem_model mem (.*);
   // free-running clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] s, e, input string n);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk);
      {regWr, regAddr, regWdata} <= {1'b1, a, v};
      @(posedge clk);
      regWr <= 0;
   endtask : wr
   task rd(input logic [4:0] a);
      @(posedge clk);
      {regRd, regAddr} <= {1'b1, a};
      @(posedge clk);
      regRd <= 0;
      @(negedge clk);
      d = regRdata;
   endtask : rd
   // fill line at a, then dirty word 1 by a store
   task fill(input logic s);
      for (int w = 0; w < 4; w++) begin
         @(posedge clk);
         {fillValid, fillLast, slow} <= {1'b1, w == 3, s};
         fillBeat <= '{A + 32'(4 * w), 32'h5000 + 32'(w)};
      end
      @(posedge clk);
      {fillValid, fillLast, storeValid} <= 3'b001;
      storeBeat <= '{A + 32'h4, 32'hbeef};
      @(posedge clk);
      storeValid <= 0;
   endtask : fill
   // issue one op, wait for done, compare beats taken
   task op(input opKind_t k, input logic [31:0] b, input logic [15:0] i, input int nb);
      int n;
      logic st;
      {b0, pf, ic, st} = {cnt, 3'b001};
      @(posedge clk);
      {opValid, opReq} <= {1'b1, k, b, i};
      @(posedge clk);
      opValid <= 0;
      for (n = 0; n < 60 && opDone !== 1'b1; n++) begin
         @(negedge clk);
         pf |= pipeFlush === 1'b1;
         if (opDone !== 1'b1 && stall !== 1'b1) st = 1'b0;
         if (icInvValid === 1'b1) {ic, icl} = {1'b1, icInvLine};
      end
      {exv, exc} = {excValid, excCause};
      if (n == 60) num_errors++;
      if (n == 60) complete_run;
      chk(32'(cnt - b0), 32'(nb), "beats");
      chk({30'h0, st, stall}, 32'h2, "stall");
   endtask : op
   task t_flush;
      fill(1);
      op(OP_FLUSH_IDX, A + 32'h100, 16'h0, 4);
      chk(log[0].addr, A, "wb addr");
      chk(log[1].data, 32'hbeef, "wb data");
      chk(log[3].addr, A + 32'hc, "wb last");
      chk(32'(exv), 32'h0, "wb exc");
      op(OP_FLUSH_IDX, A, 16'h0, 0);
      fill(0);
      op(OP_FLUSH_HIT, A + 32'h80, 16'h0, 0);
      op(OP_FLUSH_HIT, A + 32'h10, 16'hfff0, 4);
      op(OP_FLUSH_HIT, A, 16'h0, 0);
      fill(0);
      op(OP_INIT_HIT, A, 16'h0, 0);
      op(OP_FLUSH_IDX, A, 16'h0, 0);
      fill(0);
      op(OP_INIT_IDX, A + 32'h100, 16'h0, 0);
      op(OP_FLUSH_IDX, A, 16'h0, 0);
      rd(OFS_WBCOUNT);
      chk(d, 32'h2, "wb count");
      rd(OFS_STATUS);
      chk(d, 32'h5, "status wb");
      $display("flush and invalidate done");
   endtask : t_flush
   task t_exc;
      @(posedge clk);
      userMode <= 1;
      op(OP_FLUSH_IDX, 32'h8000_0000, 16'h0, 0);
      chk(exv, 0, "index exc");
      op(OP_INIT_HIT, 32'h8000_0000, 16'h0, 0);
      chk({exv, exc}, {1'b1, EXC_SUPER_ADDR}, "super");
      wr(OFS_CTRL, 32'h0);
      op(OP_INIT_HIT, 32'h8000_0000, 16'h0, 0);
      chk(32'(exv), 32'h0, "super off");
      for (int f = 0; f < 3; f++) begin
         @(posedge clk);
         {userMode, xlateFault} <= {1'b0, 3'(4 >> f)};
         op(OP_FLUSH_HIT, A, 16'h0, 0);
         chk({exv, exc}, {1'b1, 3'(f + 2)}, "fault");
      end
      @(posedge clk);
      xlateFault <= '0;
      op(OP_ICACHE_INV, 32'h0000_01e4, 16'h0, 0);
      chk({ic, icl, exv}, {1'b1, 4'hf, 1'b0}, "icache line");
      op(OP_PIPE_FLUSH, 32'h0, 16'h0, 0);
      chk({pf, exv}, 2'b10, "pipe flush");
      $display("exceptions and flushes done");
   endtask : t_exc
   task t_regs;
      rd(OFS_CTRL);
      chk(d, 32'h1, "ctrl reset");
      rd(5'h1c);
      chk(d, 32'h0, "unmapped");
      wr(OFS_CLEAR, 32'h7);
      rd(OFS_ENABLE);
      chk(d, 32'h0, "enable reset");
      chk(32'(irq), 32'h0, "irq off");
      wr(OFS_ENABLE, 32'h1);
      op(OP_PIPE_FLUSH, 32'h0, 16'h0, 0);
      rd(OFS_STATUS);
      chk({d[0], irq}, 2'b11, "done irq");
      wr(OFS_CLEAR, 32'h1);
      rd(OFS_STATUS);
      chk({d[0], irq}, 2'b00, "cleared irq");
      $display("registers done");
   endtask : t_regs
   // reset, then scenarios
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1;
      for (int l = 0; l < 8; l++) op(OP_INIT_IDX, 32'(l * 16), 16'h0, 0);
      t_regs;
      t_flush;
      t_exc;
      complete_run;
   end
endmodule : tb_cache_line_maintenance
`default_nettype wire
